// *** src/usli_line_status.sv ***
// Purpose: Line condition flags and prioritised interrupt identification of a serial element
// Assumes: All event inputs come from receive, transmit and modem logic on the same clock
// Notes: Receive buffer, holding register and modem status data are served elsewhere

`timescale 1ns/1ns
`default_nettype none

module usli_line_status
    import usli_pkg::*;
(
    // Clock, reset and freeze
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Receive side events and queue state
    input wire logic rx_char_done,
    input wire logic rx_char_parity_bad,
    input wire logic rx_char_stop_bad,
    input wire logic rx_char_break,
    input wire logic rx_queue_empty,
    input wire logic rx_queue_full,
    input wire logic rx_queue_at_trigger,
    input wire logic rx_head_parity_bad,
    input wire logic rx_head_stop_bad,
    input wire logic rx_head_break,
    input wire logic rx_queue_has_errors,
    input wire logic char_time_tick,
    // Transmit side state
    input wire logic tx_holding_to_shift,
    input wire logic tx_shift_idle,
    input wire logic tx_queue_empty,
    // Modem side
    input wire logic modem_status_pending,
    // Interrupt and mode outputs
    output logic irq_output,
    output logic queue_mode_enable
);

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    logic line_read;
    logic line_write;
    logic data_read;
    logic hold_write;
    logic ident_read;
    logic ctrl_write;
    logic enable_write;

    assign line_read = reg_read && (reg_addr == OFS_LINE);
    assign line_write = reg_write && (reg_addr == OFS_LINE);
    assign data_read = reg_read && (reg_addr == OFS_DATA);
    assign hold_write = reg_write && (reg_addr == OFS_DATA);
    assign ident_read = reg_read && (reg_addr == OFS_IDENT);
    assign ctrl_write = reg_write && (reg_addr == OFS_IDENT);
    assign enable_write = reg_write && (reg_addr == OFS_IRQ_EN);

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic rx_char_ready;
    logic overrun;
    logic rx_parity_fault;
    logic rx_stop_bit_fault;
    logic rx_line_break;
    logic tx_holding_empty;
    logic tx_all_idle;
    logic rx_queue_error_summary;
    logic [3:0] irq_enable;
    logic thr_irq_pending;
    logic [2:0] char_time_count;
    logic timeout_pending;
    logic next_rx_char_ready;
    logic next_overrun;
    logic next_rx_parity_fault;
    logic next_rx_stop_bit_fault;
    logic next_rx_line_break;
    logic next_tx_holding_empty;
    logic next_tx_all_idle;
    logic next_rx_queue_error_summary;
    logic next_queue_mode_enable;
    logic [3:0] next_irq_enable;
    logic next_thr_irq_pending;
    logic [2:0] next_char_time_count;
    logic [3:0] shown_code;
    logic [7:0] line_value;

    assign line_value = {rx_queue_error_summary, tx_all_idle, tx_holding_empty, rx_line_break,
                         rx_stop_bit_fault, rx_parity_fault, overrun, rx_char_ready};
    assign timeout_pending = queue_mode_enable && !rx_queue_empty
                             && (char_time_count == TIMEOUT_CHARS);

    // Next flag values; a hardware set always beats a software clear in the same cycle
    always_comb begin
        next_queue_mode_enable = queue_mode_enable;
        if (ctrl_write) begin
            next_queue_mode_enable = reg_wdata[QC_ENABLE];
        end
        next_irq_enable = irq_enable;
        if (enable_write) begin
            next_irq_enable = reg_wdata[3:0];
        end
        if (queue_mode_enable) begin
            next_rx_char_ready = !rx_queue_empty;
            next_overrun = (rx_char_done && rx_queue_full) || (overrun && !line_read);
            // Error bits belong to the head character only
            next_rx_parity_fault = rx_head_parity_bad && !rx_queue_empty;
            next_rx_stop_bit_fault = rx_head_stop_bad && !rx_queue_empty;
            next_rx_line_break = rx_head_break && !rx_queue_empty;
            next_tx_holding_empty = tx_queue_empty;
            next_tx_all_idle = tx_queue_empty && tx_shift_idle;
            // Summary stays up while errors remain, otherwise drops on a line read
            next_rx_queue_error_summary = rx_queue_has_errors
                || (rx_queue_error_summary && !line_read);
        end else begin
            next_rx_char_ready = rx_char_done
                || (rx_char_ready && !data_read
                    && !(line_write && !reg_wdata[LF_READY]));
            next_overrun = (rx_char_done && rx_char_ready) || (overrun && !line_read);
            next_rx_parity_fault = (rx_char_done && rx_char_parity_bad)
                || (rx_parity_fault && !line_read);
            next_rx_stop_bit_fault = (rx_char_done && rx_char_stop_bad)
                || (rx_stop_bit_fault && !line_read);
            next_rx_line_break = (rx_char_done && rx_char_break)
                || (rx_line_break && !line_read);
            next_tx_holding_empty = tx_holding_to_shift
                || (tx_holding_empty && !hold_write);
            next_tx_all_idle = next_tx_holding_empty && tx_shift_idle;
            next_rx_queue_error_summary = 1'b0;
        end
        // Holding-empty interrupt arms on a rising flag or on enabling it while empty
        next_thr_irq_pending = thr_irq_pending;
        if (ident_read && (shown_code == ID_THR_EMPTY)) begin
            next_thr_irq_pending = 1'b0;
        end
        if (hold_write) begin
            next_thr_irq_pending = 1'b0;
        end
        if ((next_tx_holding_empty && !tx_holding_empty)
            || (enable_write && reg_wdata[IE_THR_EMPTY] && !irq_enable[IE_THR_EMPTY]
                && tx_holding_empty)) begin
            next_thr_irq_pending = 1'b1;
        end
        // Idle character times, restarted by any receive or buffer read
        next_char_time_count = char_time_count;
        if (rx_char_done || data_read || rx_queue_empty) begin
            next_char_time_count = 3'h0;
        end else if (char_time_tick && (char_time_count != TIMEOUT_CHARS)) begin
            next_char_time_count = char_time_count + COUNT_ONE;
        end
    end

    // Status registers, frozen while enable is low
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_char_ready <= LINE_RESET[LF_READY];
            overrun <= LINE_RESET[LF_OVERRUN];
            rx_parity_fault <= LINE_RESET[LF_PARITY];
            rx_stop_bit_fault <= LINE_RESET[LF_STOP];
            rx_line_break <= LINE_RESET[LF_BREAK];
            tx_holding_empty <= LINE_RESET[LF_THR_EMPTY];
            tx_all_idle <= LINE_RESET[LF_ALL_IDLE];
            rx_queue_error_summary <= LINE_RESET[LF_SUMMARY];
            queue_mode_enable <= 1'b0;
            irq_enable <= IRQ_EN_RESET;
            thr_irq_pending <= 1'b0;
            char_time_count <= 3'h0;
        end else if (enable) begin
            rx_char_ready <= next_rx_char_ready;
            overrun <= next_overrun;
            rx_parity_fault <= next_rx_parity_fault;
            rx_stop_bit_fault <= next_rx_stop_bit_fault;
            rx_line_break <= next_rx_line_break;
            tx_holding_empty <= next_tx_holding_empty;
            tx_all_idle <= next_tx_all_idle;
            rx_queue_error_summary <= next_rx_queue_error_summary;
            queue_mode_enable <= next_queue_mode_enable;
            irq_enable <= next_irq_enable;
            thr_irq_pending <= next_thr_irq_pending;
            char_time_count <= next_char_time_count;
        end
    end

    // ------------------------------------------------------------
    // Interrupt ranking, freeze and read data
    // ------------------------------------------------------------
    usli_ident_state_type ident_state;
    usli_ident_state_type next_ident_state;
    logic [3:0] held_code;
    logic [3:0] next_held_code;
    logic [3:0] live_code;
    logic [7:0] next_reg_rdata;
    logic next_irq_output;
    logic line_src;
    logic rx_data_src;
    logic timeout_src;
    logic thr_src;
    logic modem_src;
    logic held_active;

    assign line_src = irq_enable[IE_LINE]
        && (overrun || rx_parity_fault || rx_stop_bit_fault || rx_line_break);
    assign rx_data_src = irq_enable[IE_RX_READY]
        && (queue_mode_enable ? rx_queue_at_trigger : rx_char_ready);
    assign timeout_src = irq_enable[IE_RX_READY] && timeout_pending;
    assign thr_src = irq_enable[IE_THR_EMPTY] && thr_irq_pending;
    assign modem_src = irq_enable[IE_MODEM] && modem_status_pending;
    assign shown_code = (ident_state == ST_FROZEN) ? held_code : live_code;

    // Ranking, fixed order keeps the data path shallow
    always_comb begin
        if (line_src) begin
            live_code = ID_LINE;
        end else if (rx_data_src) begin
            live_code = ID_RX_DATA;
        end else if (timeout_src) begin
            live_code = ID_TIMEOUT;
        end else if (thr_src) begin
            live_code = ID_THR_EMPTY;
        end else if (modem_src) begin
            live_code = ID_MODEM;
        end else begin
            live_code = ID_NONE;
        end
        case (held_code)
            ID_LINE: held_active = line_src;
            ID_RX_DATA: held_active = rx_data_src;
            ID_TIMEOUT: held_active = timeout_src;
            ID_THR_EMPTY: held_active = thr_src;
            ID_MODEM: held_active = modem_src;
            default: held_active = 1'b0;
        endcase
    end

    // Freeze on an identification read, release once the held source is serviced
    always_comb begin
        next_ident_state = ident_state;
        next_held_code = held_code;
        case (ident_state)
            ST_LIVE: begin
                if (ident_read && (live_code != ID_NONE)) begin
                    next_ident_state = ST_FROZEN;
                    next_held_code = live_code;
                end
            end
            ST_FROZEN: begin
                if (!held_active) begin
                    next_ident_state = ST_LIVE;
                    next_held_code = ID_NONE;
                end
            end
            default: begin
                next_ident_state = ST_LIVE;
                next_held_code = ID_NONE;
            end
        endcase
        next_irq_output = (shown_code != ID_NONE);
        // Read data shows the value from before any read side effect
        case (reg_addr)
            OFS_LINE: next_reg_rdata = line_value;
            OFS_IDENT: next_reg_rdata = {queue_mode_enable, queue_mode_enable,
                                         IDENT_ZERO_BITS, shown_code};
            OFS_IRQ_EN: next_reg_rdata = {UPPER_ZERO, irq_enable};
            default: next_reg_rdata = 8'h00;
        endcase
        if (!reg_read) begin
            next_reg_rdata = 8'h00;
        end
    end

    // Identification and port registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ident_state <= ST_LIVE;
            held_code <= ID_NONE;
            irq_output <= 1'b0;
            reg_rdata <= 8'h00;
        end else if (enable) begin
            ident_state <= next_ident_state;
            held_code <= next_held_code;
            irq_output <= next_irq_output;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_ident_read_live;
        enable && ident_read && (ident_state == ST_LIVE);
    endsequence

    property p_ready_set;
        enable && !queue_mode_enable && rx_char_done |=> rx_char_ready;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_overrun_set;
        enable && !queue_mode_enable && rx_char_done && rx_char_ready |=> overrun;
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("overrun missed");

    property p_overrun_clear;
        enable && line_read && !rx_char_done |=> !overrun;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");

    property p_hold_empty_clear;
        enable && !queue_mode_enable && hold_write && !tx_holding_to_shift
            |=> !tx_holding_empty && !tx_all_idle;
    endproperty
    a_hold_empty_clear: assert property (p_hold_empty_clear)
        else $error("holding empty stuck");

    property p_ident_layout;
        enable && ident_read |=> reg_rdata[5:4] == IDENT_ZERO_BITS
            && reg_rdata[7:6] == {2{$past(queue_mode_enable)}};
    endproperty
    a_ident_layout: assert property (p_ident_layout) else $error("ident upper bits");

    property p_line_first;
        s_ident_read_live ##0 line_src
            |=> reg_rdata[3:0] == ID_LINE && ident_state == ST_FROZEN && held_code == ID_LINE;
    endproperty
    a_line_first: assert property (p_line_first) else $error("line not top");

    property p_none_pending;
        s_ident_read_live ##0 (live_code == ID_NONE) |=> reg_rdata[0] && reg_rdata[3:1] == 3'h0;
    endproperty
    a_none_pending: assert property (p_none_pending) else $error("none code");

    property p_frozen_holds;
        enable && ident_state == ST_FROZEN && held_active |=> shown_code == $past(held_code);
    endproperty
    a_frozen_holds: assert property (p_frozen_holds) else $error("freeze lost");

    property p_irq_follows;
        enable && shown_code != ID_NONE |=> irq_output;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not raised");

    property p_summary_single;
        enable && !queue_mode_enable |=> !rx_queue_error_summary;
    endproperty
    a_summary_single: assert property (p_summary_single) else $error("summary set");

endmodule

`default_nettype wire

// *** src/usli_pkg.sv ***
// Purpose: Constants and types shared by the line status and interrupt identification block
// Assumes: Eight-bit register bus with a three-bit register index
// Notes: Offsets are register indices on the plain register port

package usli_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_DATA = 3'h0;    // Receive buffer read, holding register write
    localparam logic [2:0] OFS_IRQ_EN = 3'h1;  // Interrupt enables
    localparam logic [2:0] OFS_IDENT = 3'h2;   // Read: identification, write: queue control
    localparam logic [2:0] OFS_LINE = 3'h5;    // Line condition flags
    localparam logic [2:0] OFS_MODEM = 3'h6;   // Modem status, decoded elsewhere

    // ------------------------------------------------------------
    // Line condition flag positions and reset value
    // ------------------------------------------------------------
    localparam int LF_READY = 0;
    localparam int LF_OVERRUN = 1;
    localparam int LF_PARITY = 2;
    localparam int LF_STOP = 3;
    localparam int LF_BREAK = 4;
    localparam int LF_THR_EMPTY = 5;
    localparam int LF_ALL_IDLE = 6;
    localparam int LF_SUMMARY = 7;
    localparam logic [7:0] LINE_RESET = 8'h60;

    // ------------------------------------------------------------
    // Interrupt enable positions, queue control, identification layout
    // ------------------------------------------------------------
    localparam int IE_RX_READY = 0;
    localparam int IE_THR_EMPTY = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    localparam int QC_ENABLE = 0;
    localparam logic [1:0] IDENT_ZERO_BITS = 2'h0;
    localparam logic [3:0] UPPER_ZERO = 4'h0;

    // Identification codes in bits 3..0, bit 0 low while pending
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RX_DATA = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hc;
    localparam logic [3:0] ID_THR_EMPTY = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;

    // Character times of silence before a receive timeout
    localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
    localparam logic [2:0] COUNT_ONE = 3'h1;

    // Identification presentation states
    typedef enum logic [1:0] {
        ST_LIVE = 2'b01,
        ST_FROZEN = 2'b10
    } usli_ident_state_type;

endpackage

// *** bench/usli_host.sv ***
// Purpose: Host processor model on the register port
// Assumes: Read data stands only in the cycle after the strobe
// Notes: Signals move by non-blocking assignment after an edge
`timescale 1ns/1ns
`default_nettype none
module usli_host
    import usli_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output logic [ADDR_W-1:0] reg_addr = 3'h0,
    output logic [7:0] reg_wdata = 8'h0,
    output logic reg_write = 1'b0,
    output logic reg_read = 1'b0,
    input wire logic [7:0] reg_rdata
);
    // One-cycle write, also the way software clears flags
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Data is taken at the edge that closes its single valid cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for line flags and identification
// Assumes: Event inputs are set by hand, host model runs the bus
// Notes: Clock enable dropped once to check the freeze; trigger level raised in queue mode
`timescale 1ns/1ns
`default_nettype none
module tb
    import usli_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic reg_write, reg_read, irq_output, queue_mode_enable;
    logic rx_char_done = 1'b0, rx_char_parity_bad = 1'b0, rx_char_stop_bad = 1'b0;
    logic rx_char_break = 1'b0, rx_queue_empty = 1'b1, rx_queue_full = 1'b0;
    logic rx_head_parity_bad = 1'b0, rx_head_stop_bad = 1'b0, rx_head_break = 1'b0;
    logic rx_queue_has_errors = 1'b0, char_time_tick = 1'b0, tx_holding_to_shift = 1'b0;
    logic tx_shift_idle = 1'b1, tx_queue_empty = 1'b1, modem_status_pending = 1'b0;
    logic enable = 1'b1, rx_queue_at_trigger = 1'b0;
    int n_fail = 0;
    int samples_checked = 0;

    always #20 clock = ~clock;

    usli_host host(.*);
    usli_line_status uut(.*);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic exp);
        samples_checked++;
        if (irq_output !== exp) begin
            n_fail++;
            $display("MISMATCH %0t: interrupt line %b", $time, irq_output);
        end
    endtask
    // Idle cycles first, so flags and the interrupt line have settled
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        repeat (3) @(posedge clock);
        host.rd(a, d);
        chk(d, exp);
    endtask
    // One finished character with its error levels {break, stop, parity}
    task automatic rx(input logic [2:0] e);
        @(posedge clock);
        rx_char_done <= 1'b1;
        {rx_char_break, rx_char_stop_bad, rx_char_parity_bad} <= e;
        @(posedge clock);
        rx_char_done <= 1'b0;
    endtask
    task automatic stop_test;
        $display("%0d values checked, %0d mismatches", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #2000000;
        n_fail++;
        $display("MISMATCH %0t: run did not finish", $time);
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        host.wr(3'h7, 8'hff);
        rchk(3'h7, 8'h00);
        rchk(OFS_LINE, LINE_RESET);
        rchk(OFS_IDENT, 8'h01);
        chk_irq(1'b0);
        $display("reset test done");
        rx(3'h1);
        rchk(OFS_LINE, 8'h65);
        rchk(OFS_LINE, 8'h61);
        rx(3'h2);
        rchk(OFS_LINE, 8'h6b);
        rx(3'h4);
        rchk(OFS_LINE, 8'h73);
        host.wr(OFS_LINE, 8'h00);
        rchk(OFS_LINE, 8'h60);
        rx(3'h0);
        host.rd(OFS_DATA, d);
        rchk(OFS_LINE, 8'h60);
        $display("receive test done");
        host.wr(OFS_DATA, 8'h5a);
        rchk(OFS_LINE, 8'h00);
        tx_holding_to_shift <= 1'b1;
        tx_shift_idle <= 1'b0;
        @(posedge clock);
        tx_holding_to_shift <= 1'b0;
        rchk(OFS_LINE, 8'h20);
        tx_shift_idle <= 1'b1;
        rchk(OFS_LINE, 8'h60);
        $display("transmit test done");
        // Four of the five sources pending at once (no timeout outside queue mode), serviced top down
        modem_status_pending <= 1'b1;
        rx(3'h2);
        host.wr(OFS_IRQ_EN, 8'h0f);
        rchk(OFS_IDENT, 8'h06);
        chk_irq(1'b1);
        rchk(OFS_LINE, 8'h69);
        rchk(OFS_IDENT, 8'h04);
        host.rd(OFS_DATA, d);
        rchk(OFS_IDENT, 8'h02);
        rchk(OFS_IDENT, 8'h00);
        modem_status_pending <= 1'b0;
        rchk(OFS_IDENT, 8'h01);
        chk_irq(1'b0);
        host.wr(OFS_IRQ_EN, 8'h0b);
        rx(3'h1);
        rchk(OFS_IDENT, 8'h04);
        host.wr(OFS_IRQ_EN, 8'h00);
        rchk(OFS_IDENT, 8'h01);
        rchk(OFS_LINE, 8'h65);
        host.rd(OFS_DATA, d);
        // Clock enable low: neither the character nor the enable write may land
        enable <= 1'b0;
        rx(3'h1);
        host.wr(OFS_IRQ_EN, 8'h0f);
        enable <= 1'b1;
        rchk(OFS_LINE, 8'h60);
        rchk(OFS_IDENT, 8'h01);
        // Holding-empty interrupt armed by its enable, cleared by a holding write
        host.wr(OFS_IRQ_EN, 8'h02);
        rchk(OFS_LINE, 8'h60);
        chk_irq(1'b1);
        host.wr(OFS_DATA, 8'h00);
        rchk(OFS_IDENT, 8'h01);
        chk_irq(1'b0);
        host.wr(OFS_IRQ_EN, 8'h00);
        $display("interrupt test done");
        // Queue mode: full queue, errored head, then receive silence
        host.wr(OFS_IDENT, 8'h01);
        rchk(OFS_IDENT, 8'hc1);
        chk({7'h0, queue_mode_enable}, 8'h01);
        tx_queue_empty <= 1'b0;
        rx_queue_empty <= 1'b0;
        rx_queue_full <= 1'b1;
        rx_queue_has_errors <= 1'b1;
        {rx_head_break, rx_head_stop_bad, rx_head_parity_bad} <= 3'h7;
        rx(3'h0);
        rchk(OFS_LINE, 8'h9f);
        rchk(OFS_LINE, 8'h9d);
        host.wr(OFS_IRQ_EN, 8'h01);
        repeat (4) begin
            @(posedge clock);
            char_time_tick <= 1'b1;
            @(posedge clock);
            char_time_tick <= 1'b0;
        end
        rchk(OFS_IDENT, 8'hcc);
        host.rd(OFS_DATA, d);
        rchk(OFS_IDENT, 8'hc1);
        // Trigger level reached: received data source in queue mode
        rx_queue_at_trigger <= 1'b1;
        rchk(OFS_IDENT, 8'hc4);
        rx_queue_at_trigger <= 1'b0;
        rchk(OFS_IDENT, 8'hc1);
        rx_queue_empty <= 1'b1;
        rx_queue_full <= 1'b0;
        rx_queue_has_errors <= 1'b0;
        tx_queue_empty <= 1'b1;
        host.rd(OFS_LINE, d);
        rchk(OFS_LINE, 8'h60);
        $display("queue test done");
        stop_test();
    end
endmodule
`default_nettype wire
